// [peiu_pkg.sv]
// Package of register map and field positions for the PHY event interrupt unit
package peiu_pkg;
  localparam logic [4:0] CTRL_ADDR = 5'h11;
  localparam logic [4:0] STAT_ADDR = 5'h12;
  localparam int CTRL_OE_BIT = 0;
  localparam int CTRL_GEN_BIT = 1;
  localparam int CTRL_TEST_BIT = 2;
  localparam int NUM_EVENTS = 8;
  localparam int EV_LINKQ = 7;
  localparam int EV_ENERGY = 6;
  localparam int EV_LINK = 5;
  localparam int EV_SPEED = 4;
  localparam int EV_DUPLEX = 3;
  localparam int EV_ANEG = 2;
  localparam int EV_FALSEC = 1;
  localparam int EV_RXERR = 0;
  localparam int CNT_MSB = 7;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam int SUMMARY_PEND_BIT = 7;
endpackage : peiu_pkg

// [peiu_phy_event_interrupt_unit.sv]
// Event interrupt unit: status latches, enables, counters and shared pin control
// Functional notes
// - Link quality, energy, link, speed, duplex, autoneg, counter-half events
// - Status bits latch regardless of enables
// - Status read returns bits and clears them
// - Event irq needs own and global enable
// - Test bit forces continuous interrupt
// - Control bit 0 selects pin role
// - Control bits 15:3 read zero, ignore writes
// - Status byte order fixed in bits 15:8
// - Enable byte read/write, matches status bit
// - Counter half-full events in bits 9, 8
// - Eight-bit counters saturate at maximum
// - Summary pending flag cleared by status read
`timescale 1ns/10ps
`default_nettype none
module peiu_phy_event_interrupt_unit
  import peiu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Management register access
  input wire logic [4:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  // Event sources
  input wire logic linkQualityEvent,
  input wire logic energyDetect,
  input wire logic linkStatus,
  input wire logic speedStatus,
  input wire logic duplexStatus,
  input wire logic autonegDone,
  input wire logic falseCarrierPulse,
  input wire logic rxErrorPulse,
  input wire logic falseCarrierClear,
  input wire logic rxErrorClear,
  // Shared power-down or interrupt pin
  input wire logic powerdownOrIrqPinIn,
  output logic powerdownOrIrqPinOut,
  output logic powerdownOrIrqPinOe,
  output logic powerdownRequest,
  // Summary status
  output logic interruptPending
);
  // Register state
  logic [2:0] interruptControl;
  logic [7:0] eventStatus;
  logic [7:0] eventEnable;
  // Event detection
  logic [7:0] eventRaw;
  logic [7:0] next_eventStatus;
  logic [3:0] curLevels;
  logic [3:0] prevLevels;
  logic prevAneg;
  logic anegRise;
  // Error counters, index 1 false carrier and index 0 receive error
  logic [1:0] errPulse;
  logic [1:0] errClear;
  logic [1:0] halfFullRise;
  // Register access decode
  logic ctrlSel;
  logic statSel;
  logic ctrlWr;
  logic statWr;
  logic statRd;
  logic [15:0] ctrlView;
  logic [15:0] statView;
  logic [15:0] next_rdData;
  // Interrupt request
  logic [7:0] maskedStatus;
  logic [7:0] next_maskedStatus;
  logic globalEnable;
  logic testForce;
  logic pinIsIrq;
  logic eventIrq;
  logic irqReq;
  logic next_pending;
  logic next_pdRequest;
  logic [2:0] next_control;
  logic [7:0] next_enable;

  // Register access decode
  assign ctrlSel = (regAddr == CTRL_ADDR);
  assign statSel = (regAddr == STAT_ADDR);
  assign ctrlWr = regWrite && ctrlSel;
  assign statWr = regWrite && statSel;
  assign statRd = regRead && statSel;
  assign next_control = ctrlWr ? regWrData[CTRL_TEST_BIT:CTRL_OE_BIT] : interruptControl;
  assign next_enable = statWr ? regWrData[NUM_EVENTS-1:0] : eventEnable;

  // Level change detectors, duplex at index 0 up to energy detect at index 3
  assign curLevels = {energyDetect, linkStatus, speedStatus, duplexStatus};
  generate
    for (genvar j = 0; j < 4; j++)
    begin : g_level
      assign eventRaw[EV_DUPLEX + j] = curLevels[j] ^ prevLevels[j];
    end
  endgenerate

  // Pulse and rising edge events
  assign anegRise = autonegDone && !prevAneg;
  assign eventRaw[EV_LINKQ] = linkQualityEvent;
  assign eventRaw[EV_ANEG] = anegRise;

  // Saturating error counters, clear beats increment
  assign errPulse = {falseCarrierPulse, rxErrorPulse};
  assign errClear = {falseCarrierClear, rxErrorClear};
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_counter
      logic [7:0] count;
      logic [7:0] next_count;
      logic lastMsb;
      assign next_count = errClear[i] ? CNT_RESET :
        ((errPulse[i] && (count != CNT_MAX)) ? count + 8'h01 : count);
      assign halfFullRise[i] = count[CNT_MSB] && !lastMsb;
      assign eventRaw[EV_RXERR + i] = halfFullRise[i];
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          count <= CNT_RESET;
        else
          count <= next_count;
      end
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          lastMsb <= 1'b0;
        else
          lastMsb <= count[CNT_MSB];
      end
    end
  endgenerate

  // Status latches, a new event wins over the clear of a read
  assign next_eventStatus = (statRd ? EVENT_RESET : eventStatus) | eventRaw;

  // Interrupt request
  assign globalEnable = interruptControl[CTRL_GEN_BIT];
  assign testForce = interruptControl[CTRL_TEST_BIT];
  assign pinIsIrq = interruptControl[CTRL_OE_BIT];
  assign maskedStatus = eventStatus & eventEnable;
  assign next_maskedStatus = next_eventStatus & eventEnable;
  assign eventIrq = globalEnable && (|maskedStatus);
  assign irqReq = eventIrq || testForce;
  assign next_pending = (globalEnable && (|next_maskedStatus)) || testForce;
  assign next_pdRequest = !pinIsIrq && !powerdownOrIrqPinIn;

  // Read data selection, unmapped addresses read zero
  assign ctrlView = {13'h0000, interruptControl};
  assign statView = {eventStatus, eventEnable};
  assign next_rdData = ctrlSel ? ctrlView : (statSel ? statView : 16'h0000);

  // Control register, only the three defined bits are stored
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      interruptControl <= CTRL_RESET;
    else
      interruptControl <= next_control;
  end

  // Event enables
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      eventEnable <= EVENT_RESET;
    else
      eventEnable <= next_enable;
  end

  // Event status, latched whatever the enables say
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      eventStatus <= EVENT_RESET;
    else
      eventStatus <= next_eventStatus;
  end

  // Previous levels for change and edge detection
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prevLevels <= 4'h0;
      prevAneg <= 1'b0;
    end
    else
    begin
      prevLevels <= curLevels;
      prevAneg <= autonegDone;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 16'h0000;
    else if (regRead)
      regRdData <= next_rdData;
  end

  // Shared pin direction
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      powerdownOrIrqPinOe <= 1'b0;
    else
      powerdownOrIrqPinOe <= pinIsIrq;
  end

  // Interrupt level on the shared pin, low while asserted
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      powerdownOrIrqPinOut <= 1'b1;
    else
      powerdownOrIrqPinOut <= !irqReq;
  end

  // Power-down request while the pin is an input
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      powerdownRequest <= 1'b0;
    else
      powerdownRequest <= next_pdRequest;
  end

  // Summary pending flag
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      interruptPending <= 1'b0;
    else
      interruptPending <= next_pending;
  end
endmodule : peiu_phy_event_interrupt_unit
`default_nettype wire

// [peiu_host.sv]
// Host model issuing management register writes and reads
`timescale 1ns/10ps
`default_nettype none
module peiu_host
(
  // Register bus, host side
  input wire logic ref_clk,
  input wire logic [15:0] regRdData,
  output logic [4:0] regAddr = 5'h00,
  output logic regRead = 1'b0,
  output logic regWrite = 1'b0,
  output logic [15:0] regWrData = 16'h0000
);
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : rd
endmodule : peiu_host
`default_nettype wire

// [peiu_chk.sv]
// Checker for register reads and pin behaviour
`timescale 1ns/10ps
`default_nettype none
module peiu_chk
  import peiu_pkg::*;
(
  // Watched ports
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic powerdownOrIrqPinIn,
  input wire logic powerdownOrIrqPinOut,
  input wire logic powerdownOrIrqPinOe,
  input wire logic powerdownRequest,
  input wire logic interruptPending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence ctlRd; regRead && regAddr == CTRL_ADDR ##1 1'b1; endsequence
  a_ctrl_rsvd_zero: assert property (ctlRd |-> regRdData[15:3] == 13'h0000) else $error("ctrl");
  a_test_irq_on: assert property (ctlRd ##0 regRdData[2] |-> interruptPending) else $error("test");
  a_gen_gate_off: assert property (ctlRd ##0 regRdData[2:1] == 2'h0 |-> !interruptPending)
    else $error("gate");
  a_unmapped_read: assert property (regRead && regAddr != CTRL_ADDR && regAddr != STAT_ADDR
    |=> regRdData == 16'h0000) else $error("unmapped");
  a_read_holds: assert property (!regRead |=> $stable(regRdData)) else $error("hold");
  sequence enWrGap; regWrite && regAddr == STAT_ADDR ##1 !regWrite && !regRead; endsequence
  sequence statRdReq; regRead && regAddr == STAT_ADDR; endsequence
  a_enable_readback: assert property (enWrGap ##1 statRdReq
    |=> regRdData[7:0] == $past(regWrData[7:0], 3))
    else $error("enable");
  a_pin_level: assert property ((powerdownOrIrqPinOe && $stable(interruptPending))[*3]
    |-> powerdownOrIrqPinOut == !interruptPending) else $error("pin");
  a_pd_request: assert property ((!powerdownOrIrqPinOe && $stable(powerdownOrIrqPinIn))[*2]
    |-> powerdownRequest == !powerdownOrIrqPinIn) else $error("pdreq");
endmodule : peiu_chk
bind peiu_phy_event_interrupt_unit peiu_chk u_chk (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .regAddr(regAddr),
  .regRead(regRead),
  .regWrite(regWrite),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .powerdownOrIrqPinIn(powerdownOrIrqPinIn),
  .powerdownOrIrqPinOut(powerdownOrIrqPinOut),
  .powerdownOrIrqPinOe(powerdownOrIrqPinOe),
  .powerdownRequest(powerdownRequest),
  .interruptPending(interruptPending)
);
`default_nettype wire

// [peiu_phy_event_interrupt_unit_tb.sv]
// Self-checking bench for the event interrupt unit
`timescale 1ns/10ps
`default_nettype none
module peiu_phy_event_interrupt_unit_tb
  import peiu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic pinIn = 1'b1;
  logic [5:0] lv = 6'h00;
  logic [1:0] cp = 2'h0;
  logic [1:0] cl = 2'h0;
  logic [4:0] ad;
  logic rs, ws, pinOut, pinOe, pdReq, pend;
  logic [15:0] wd, rdd, rd;
  int err_count = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  peiu_host u_host (.ref_clk(ref_clk), .regRdData(rdd), .regAddr(ad), .regRead(rs), .regWrite(ws),
    .regWrData(wd));
  peiu_phy_event_interrupt_unit DUT (.ref_clk(ref_clk), .nrst(nrst), .regAddr(ad), .regRead(rs),
    .regWrite(ws), .regWrData(wd), .regRdData(rdd), .linkQualityEvent(lv[5]), .energyDetect(lv[4]),
    .linkStatus(lv[3]), .speedStatus(lv[2]), .duplexStatus(lv[1]), .autonegDone(lv[0]),
    .falseCarrierPulse(cp[1]), .rxErrorPulse(cp[0]), .falseCarrierClear(cl[1]), .rxErrorClear(cl[0]),
    .powerdownOrIrqPinIn(pinIn), .powerdownOrIrqPinOut(pinOut), .powerdownOrIrqPinOe(pinOe),
    .powerdownRequest(pdReq), .interruptPending(pend));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic t_regs;
    u_host.wr(CTRL_ADDR, 16'hfff8);
    u_host.rd(CTRL_ADDR, rd);
    chk("ctrl", 16'h0000, rd);
    u_host.wr(STAT_ADDR, 16'hff5a);
    u_host.rd(STAT_ADDR, rd);
    chk("enable", 16'h005a, rd);
    u_host.rd(5'h00, rd);
    chk("unmapped", 16'h0000, rd);
  endtask : t_regs
  task automatic t_events;
    @(posedge ref_clk);
    lv <= 6'h3f;
    cp <= 2'h3;
    @(posedge ref_clk);
    lv[5] <= 1'b0;
    repeat (127) @(posedge ref_clk);
    cp <= 2'h0;
    settle(3);
    chk("masked", 16'h0000, {15'h0000, pend});
    u_host.rd(STAT_ADDR, rd);
    chk("events", 16'hff5a, rd);
    @(posedge ref_clk);
    cp <= 2'h3;
    repeat (256) @(posedge ref_clk);
    cp <= 2'h0;
    u_host.rd(STAT_ADDR, rd);
    chk("saturate", 16'h005a, rd);
    @(posedge ref_clk);
    cl <= 2'h3;
    @(posedge ref_clk);
    cl <= 2'h0;
    cp <= 2'h1;
    repeat (128) @(posedge ref_clk);
    cp <= 2'h0;
    u_host.rd(STAT_ADDR, rd);
    chk("recross", 16'h015a, rd);
  endtask : t_events
  task automatic t_irq;
    u_host.wr(CTRL_ADDR, 16'h0003);
    lv[3] <= 1'b0;
    settle(4);
    chk("linkoff", 16'h0001, {7'h00, pend, 7'h00, pinOut});
    @(posedge ref_clk);
    lv[2] <= 1'b0;
    settle(4);
    chk("irq", 16'h0100, {7'h00, pend, 7'h00, pinOut});
    u_host.rd(STAT_ADDR, rd);
    chk("ack", 16'h305a, rd);
    settle(3);
    chk("rel", 16'h0001, {7'h00, pend, 7'h00, pinOut});
  endtask : t_irq
  task automatic t_pin;
    u_host.wr(CTRL_ADDR, 16'h0005);
    u_host.rd(CTRL_ADDR, rd);
    chk("test", 16'h0105, {7'h00, pend, rd[7:0]});
    chk("testpin", 16'h0100, {7'h00, pinOe, 7'h00, pinOut});
    u_host.wr(CTRL_ADDR, 16'h0000);
    pinIn <= 1'b0;
    settle(4);
    chk("pdreq", 16'h0001, {7'h00, pend, 7'h00, pdReq});
  endtask : t_pin
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_events();
    t_irq();
    t_pin();
    wrap_up();
  end
endmodule : peiu_phy_event_interrupt_unit_tb
`default_nettype wire
